// file: shared/uart_consts.svh
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH
`define HOLD_OFF     8'h00
`define MASK_OFF     8'h04
`define SRC_OFF      8'h08
`define LINE_OFF     8'h0C
`define FC_ENABLE    0
`define FC_RX_FLUSH  1
`define FC_TX_FLUSH  2
`define FC_DMA       3
`define FC_TXTRIG    4
`define FC_RXTRIG    6
`define MK_RX        0
`define MK_TX        1
`define MK_LINE      2
`define LS_READY     0
`define LS_OVERRUN   1
`define LS_PARITY    2
`define LS_FRAMING   3
`define LS_BREAK     4
`define LS_TX_EMPTY  5
`define LS_TX_IDLE   6
`define LS_FIFO_ERR  7
`define MASK_RESET   4'h0
`define TRIG_RESET   2'h0
`define RX_TRIG0     6'h08
`define RX_TRIG1     6'h10
`define RX_TRIG2     6'h18
`define RX_TRIG3     6'h1C
`define TX_TRIG0     6'h10
`define TX_TRIG1     6'h08
`define TX_TRIG2     6'h18
`define TX_TRIG3     6'h1E
`define SRC_NONE     6'h01
`define SRC_LINE     6'h06
`define SRC_RX       6'h04
`define SRC_TIMEOUT  6'h0C
`define SRC_TX       6'h02
`define TIMEOUT_CHARS 3'h4
`endif

// file: shared/uart_pkg.sv
package uart_pkg;
    typedef logic [5:0] count_t;
    typedef logic [7:0] byte_t;
    typedef logic [5:0] src_t;
    typedef logic [2:0] err_t;
endpackage

// file: rtl/uart_fifo_irq_dma.sv
// What this block does
// - Receive level interrupt follows trigger level
// - Source register shows receive trigger while reached
// - Data ready set on push, cleared empty
// - Transmit drain interrupt, cleared by read/write
// - All mask bits zero means no interrupt
// - Error type and break shown in status
// - Status bit five while transmit FIFO empty
// - Bit six when FIFO and shifter empty
// - Bit seven when any stored character erroneous
// - DMA select bit picks mode zero/one
// - Receive trigger bits pick threshold; keep filling
// - Transmit trigger default 16; mode one fires below level, otherwise at empty
// - Mode zero transmit request low when empty
// - Mode zero receive request low while data
// - Mode one transmit request: full high, trigger low
// - Mode one receive request: trigger/timeout low, empty high
// - Mode zero requests per single character
// - Receive thresholds 8, 16, 24, 28
// - Transmit thresholds 16, 8, 24, 30
// - Control bits ignored unless enable written one
// - Source codes and receive over transmit priority
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`include "uart_consts.svh"
module uart_fifo_irq_dma #(
    parameter int DEPTH = 32
) (
    input  wire logic           clock,
    input  wire logic           rst,
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic           hready,
    input  wire logic [31:0]    hwdata,
    output logic      [31:0]    hrdata,
    output logic                hreadyout,
    output logic                hresp,
    input  wire logic           rx_push,
    input  wire uart_pkg::byte_t rx_push_data,
    input  wire uart_pkg::err_t rx_push_err,
    input  wire logic           char_tick,
    output logic                tx_valid,
    output uart_pkg::byte_t     tx_data,
    input  wire logic           tx_pop,
    input  wire logic           tx_shifter_empty,
    output logic                irq,
    output logic                tx_request_n,
    output logic                rx_request_n
);
    import uart_pkg::*;
    localparam int PW = $clog2(DEPTH);

    logic            wr_pend_r, wr_pend_nxt;
    logic [7:0]      wr_addr_r, wr_addr_nxt;
    logic [31:0]     hrdata_r, hrdata_nxt, rd_word;
    logic [3:0]      mask_r, mask_nxt;
    logic            fifo_en_r, fifo_en_nxt, dma_r, dma_nxt;
    logic [1:0]      rxtrig_r, rxtrig_nxt, txtrig_r, txtrig_nxt;
    logic            rx_flush, tx_flush, take, rd;
    logic [7:0]      off;
    logic [10:0]     rx_mem [DEPTH];
    byte_t           tx_mem [DEPTH];
    logic [PW-1:0]   rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
    logic [PW-1:0]   tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
    count_t          rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
    count_t          err_cnt_r, err_cnt_nxt, cap, rx_level, tx_level;
    logic            ovr_r, ovr_nxt, tmo_r, tmo_nxt;
    logic [2:0]      tmo_cnt_r, tmo_cnt_nxt;
    logic            tx_pend_r, tx_pend_nxt, txr_n_r, txr_n_nxt;
    logic            rxr_n_r, rxr_n_nxt;
    logic            rx_do_push, rx_pop, tx_wr, tx_do_push, tx_do_pop;
    logic            rx_hit, line_cond, src_rd;
    err_t            head_err;
    byte_t           ls;
    src_t            src;

    assign take = hsel && hready && htrans[1];
    assign rd = take && !hwrite;
    assign off = haddr[7:0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign src_rd = rd && off == `SRC_OFF;

    // Register writes act in the data phase, reads are sampled in the
    // address phase so read side effects line up with the captured data
    always_comb begin
        wr_pend_nxt = take && hwrite;
        wr_addr_nxt = take ? off : wr_addr_r;
        hrdata_nxt = rd ? rd_word : hrdata_r;
        mask_nxt = mask_r;
        fifo_en_nxt = fifo_en_r;
        dma_nxt = dma_r;
        rxtrig_nxt = rxtrig_r;
        txtrig_nxt = txtrig_r;
        rx_flush = 1'b0;
        tx_flush = 1'b0;
        if (wr_pend_r && wr_addr_r == `MASK_OFF) begin
            mask_nxt = hwdata[3:0];
        end
        if (wr_pend_r && wr_addr_r == `SRC_OFF) begin
            fifo_en_nxt = hwdata[`FC_ENABLE];
            if (hwdata[`FC_ENABLE]) begin
                dma_nxt = hwdata[`FC_DMA];
                rxtrig_nxt = hwdata[`FC_RXTRIG +: 2];
                txtrig_nxt = hwdata[`FC_TXTRIG +: 2];
                rx_flush = hwdata[`FC_RX_FLUSH];
                tx_flush = hwdata[`FC_TX_FLUSH];
            end
            // Changing FIFO mode empties both sides
            if (hwdata[`FC_ENABLE] != fifo_en_r) begin
                rx_flush = 1'b1;
                tx_flush = 1'b1;
            end
        end
    end

    always_comb begin
        case (rxtrig_r)
            2'h0:    rx_level = `RX_TRIG0;
            2'h1:    rx_level = `RX_TRIG1;
            2'h2:    rx_level = `RX_TRIG2;
            default: rx_level = `RX_TRIG3;
        endcase
        case (txtrig_r)
            2'h0:    tx_level = `TX_TRIG0;
            2'h1:    tx_level = `TX_TRIG1;
            2'h2:    tx_level = `TX_TRIG2;
            default: tx_level = `TX_TRIG3;
        endcase
    end

    // Without FIFOs each side holds a single character
    assign cap = fifo_en_r ? count_t'(DEPTH) : 6'h01;
    assign head_err = rx_mem[rx_rp_r][10:8];
    assign rx_hit = fifo_en_r ? rx_cnt_r >= rx_level : rx_cnt_r != 6'h00;
    assign line_cond = ovr_r || (rx_cnt_r != 6'h00 && head_err != 3'h0);

    always_comb begin
        rx_do_push = rx_push && !rx_flush && rx_cnt_r < cap;
        rx_pop = rd && off == `HOLD_OFF && rx_cnt_r != 6'h00;
        rx_wp_nxt = rx_wp_r;
        rx_rp_nxt = rx_rp_r;
        rx_cnt_nxt = rx_cnt_r;
        err_cnt_nxt = err_cnt_r;
        if (rx_flush) begin
            rx_wp_nxt = '0;
            rx_rp_nxt = '0;
            rx_cnt_nxt = 6'h00;
            err_cnt_nxt = 6'h00;
        end else begin
            rx_wp_nxt = rx_wp_r + PW'(rx_do_push);
            rx_rp_nxt = rx_rp_r + PW'(rx_pop);
            rx_cnt_nxt = rx_cnt_r + 6'(rx_do_push) - 6'(rx_pop);
            err_cnt_nxt = err_cnt_r + 6'(rx_do_push && rx_push_err != 3'h0)
                        - 6'(rx_pop && head_err != 3'h0);
        end
        // Overrun clears by a status read; a new overrun wins
        ovr_nxt = ovr_r;
        if (rd && off == `LINE_OFF) begin
            ovr_nxt = 1'b0;
        end
        if (rx_push && !rx_flush && rx_cnt_r >= cap) begin
            ovr_nxt = 1'b1;
        end
        tmo_cnt_nxt = tmo_cnt_r;
        tmo_nxt = tmo_r;
        if (!fifo_en_r || rx_do_push || rx_pop || rx_flush ||
            rx_cnt_r == 6'h00 || rx_cnt_r >= rx_level) begin
            tmo_cnt_nxt = 3'h0;
            tmo_nxt = 1'b0;
        end else if (char_tick && !tmo_r) begin
            tmo_cnt_nxt = tmo_cnt_r + 3'h1;
            tmo_nxt = tmo_cnt_nxt == `TIMEOUT_CHARS;
        end
    end

    assign tx_wr = wr_pend_r && wr_addr_r == `HOLD_OFF;
    assign tx_valid = tx_cnt_r != 6'h00;
    assign tx_data = tx_mem[tx_rp_r];

    always_comb begin
        tx_do_push = tx_wr && tx_cnt_r < cap;
        tx_do_pop = tx_pop && tx_cnt_r != 6'h00 && !tx_flush;
        tx_wp_nxt = tx_flush ? '0 : tx_wp_r + PW'(tx_do_push);
        tx_rp_nxt = tx_flush ? '0 : tx_rp_r + PW'(tx_do_pop);
        tx_cnt_nxt = tx_flush ? 6'h00
                   : tx_cnt_r + 6'(tx_do_push) - 6'(tx_do_pop);
        tx_pend_nxt = tx_pend_r;
        if (src_rd || tx_wr) begin
            tx_pend_nxt = 1'b0;
        end
        // Mode one drains to below the trigger, otherwise to empty
        if (tx_do_pop && (fifo_en_r && dma_r ? tx_cnt_nxt < tx_level
                                             : tx_cnt_nxt == 6'h00)) begin
            tx_pend_nxt = 1'b1;
        end
    end

    always_comb begin
        if (!fifo_en_r || !dma_r) begin
            txr_n_nxt = tx_cnt_r != 6'h00;
            rxr_n_nxt = rx_cnt_r == 6'h00;
        end else begin
            txr_n_nxt = txr_n_r;
            if (tx_cnt_r == cap) begin
                txr_n_nxt = 1'b1;
            end else if (tx_cnt_r < tx_level) begin
                txr_n_nxt = 1'b0;
            end
            rxr_n_nxt = rxr_n_r;
            if (rx_cnt_r == 6'h00) begin
                rxr_n_nxt = 1'b1;
            end else if (rx_hit || tmo_r) begin
                rxr_n_nxt = 1'b0;
            end
        end
    end

    always_comb begin
        ls = 8'h00;
        ls[`LS_READY] = rx_cnt_r != 6'h00;
        ls[`LS_OVERRUN] = ovr_r;
        if (rx_cnt_r != 6'h00) begin
            ls[`LS_PARITY] = head_err[0];
            ls[`LS_FRAMING] = head_err[1];
            ls[`LS_BREAK] = head_err[2];
        end
        ls[`LS_TX_EMPTY] = tx_cnt_r == 6'h00;
        ls[`LS_TX_IDLE] = tx_cnt_r == 6'h00 && tx_shifter_empty;
        ls[`LS_FIFO_ERR] = err_cnt_r != 6'h00;
        // Priority: line errors, receive level, timeout, transmit
        if (mask_r[`MK_LINE] && line_cond) begin
            src = `SRC_LINE;
        end else if (mask_r[`MK_RX] && rx_hit) begin
            src = `SRC_RX;
        end else if (mask_r[`MK_RX] && tmo_r) begin
            src = `SRC_TIMEOUT;
        end else if (mask_r[`MK_TX] && tx_pend_r) begin
            src = `SRC_TX;
        end else begin
            src = `SRC_NONE;
        end
        case (off)
            `HOLD_OFF: rd_word = {24'h00_0000, rx_mem[rx_rp_r][7:0]};
            `MASK_OFF: rd_word = {28'h000_0000, mask_r};
            `SRC_OFF:  rd_word = {26'h000_0000, src};
            `LINE_OFF: rd_word = {24'h00_0000, ls};
            default:   rd_word = 32'h0000_0000;
        endcase
    end

    assign irq = src != `SRC_NONE;
    assign tx_request_n = txr_n_r;
    assign rx_request_n = rxr_n_r;

    always_ff @(posedge clock) begin
        if (rx_do_push) begin
            rx_mem[rx_wp_r] <= {rx_push_err, rx_push_data};
        end
        if (tx_do_push) begin
            tx_mem[tx_wp_r] <= hwdata[7:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            mask_r <= `MASK_RESET;
            fifo_en_r <= 1'b0;
            dma_r <= 1'b0;
            rxtrig_r <= `TRIG_RESET;
            txtrig_r <= `TRIG_RESET;
            rx_wp_r <= '0;
            rx_rp_r <= '0;
            tx_wp_r <= '0;
            tx_rp_r <= '0;
            rx_cnt_r <= 6'h00;
            tx_cnt_r <= 6'h00;
            err_cnt_r <= 6'h00;
            ovr_r <= 1'b0;
            tmo_r <= 1'b0;
            tmo_cnt_r <= 3'h0;
            tx_pend_r <= 1'b0;
            txr_n_r <= 1'b1;
            rxr_n_r <= 1'b1;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata_r <= hrdata_nxt;
            mask_r <= mask_nxt;
            fifo_en_r <= fifo_en_nxt;
            dma_r <= dma_nxt;
            rxtrig_r <= rxtrig_nxt;
            txtrig_r <= txtrig_nxt;
            rx_wp_r <= rx_wp_nxt;
            rx_rp_r <= rx_rp_nxt;
            tx_wp_r <= tx_wp_nxt;
            tx_rp_r <= tx_rp_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            err_cnt_r <= err_cnt_nxt;
            ovr_r <= ovr_nxt;
            tmo_r <= tmo_nxt;
            tmo_cnt_r <= tmo_cnt_nxt;
            tx_pend_r <= tx_pend_nxt;
            txr_n_r <= txr_n_nxt;
            rxr_n_r <= rxr_n_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence tx_drain_s;
        tx_do_pop && tx_cnt_r == 6'h01 && !tx_flush;
    endsequence
    sequence fc_off_write_s;
        wr_pend_r && wr_addr_r == `SRC_OFF && !hwdata[`FC_ENABLE];
    endsequence

    tx_drain_irq_a: assert property (tx_drain_s |=> tx_pend_r)
        else $error("drain did not raise transmit interrupt");
    tx_clear_a: assert property (tx_pend_r && src_rd && !tx_do_pop
        |=> !tx_pend_r) else $error("source read left transmit pending");
    polled_quiet_a: assert property (mask_r == 4'h0 |-> !irq)
        else $error("interrupt while all masks clear");
    rx_level_a: assert property (mask_r[`MK_RX] && !mask_r[`MK_LINE]
        && fifo_en_r && rx_cnt_r >= rx_level |-> irq && src == `SRC_RX)
        else $error("receive level interrupt missing");
    ready_bit_a: assert property (rx_do_push |=> ls[`LS_READY])
        else $error("data ready not set after push");
    fc_ignored_a: assert property (fc_off_write_s |=> $stable(dma_r)
        && $stable(rxtrig_r) && $stable(txtrig_r))
        else $error("control bits taken without enable");
    tx_req_m0_a: assert property (!dma_r && tx_cnt_r == 6'h00
        ##1 !dma_r |-> !tx_request_n) else $error("mode 0 tx request");
    tx_req_full_a: assert property (fifo_en_r && dma_r
        && tx_cnt_r == count_t'(DEPTH) |=> tx_request_n)
        else $error("full FIFO still requesting");
    rx_req_empty_a: assert property (rx_cnt_r == 6'h00
        |=> rx_request_n) else $error("rx request with empty FIFO");
    timeout_cause_a: assert property ($rose(tmo_r) |-> fifo_en_r
        && rx_cnt_r != 6'h00 && rx_cnt_r < rx_level && $past(char_tick))
        else $error("timeout without idle partial FIFO");
    idle_bit_a: assert property (ls[`LS_TX_IDLE] |-> tx_cnt_r == 6'h00
        && tx_shifter_empty) else $error("idle bit with data left");
endmodule

// file: test/uart_line_model.sv
module uart_line_model (
    input  wire logic            clock,
    input  wire logic            tick_en,
    input  wire logic            tx_valid,
    input  wire uart_pkg::byte_t tx_data,
    output logic                 rx_push,
    output uart_pkg::byte_t      rx_push_data,
    output uart_pkg::err_t       rx_push_err,
    output logic                 char_tick,
    output logic                 tx_pop,
    output logic                 tx_shifter_empty
);
    timeunit 1ns;
    timeprecision 1ps;
    import uart_pkg::*;
    byte_t      got_q[$];
    logic [3:0] tk;

    initial begin
        rx_push = 1'b0;
        rx_push_data = 8'h00;
        rx_push_err = 3'h0;
        char_tick = 1'b0;
        tx_pop = 1'b0;
        tx_shifter_empty = 1'b1;
        tk = 4'h0;
    end

    // One character time is ten clocks, only while the line is active
    always @(posedge clock) begin
        tk <= (tk == 4'h9) ? 4'h0 : tk + 4'h1;
        char_tick <= tick_en && (tk == 4'h9);
    end

    task automatic send(input byte_t d, input err_t e);
        rx_push <= 1'b1;
        rx_push_data <= d;
        rx_push_err <= e;
        @(posedge clock);
        rx_push <= 1'b0;
        // Released lines show the inverse so stale values never match
        rx_push_data <= ~d;
        rx_push_err <= ~e;
        @(posedge clock);
    endtask

    // Takes n characters; the shifter stays busy hold + 1 cycles after each
    task automatic drain(input int n, input int hold);
        int k;
        repeat (n) begin
            k = 0;
            while (tx_valid !== 1'b1 && k < 100) begin
                @(posedge clock);
                k++;
            end
            // A stalled source leaves an unknown so the compare fails
            got_q.push_back((k < 100) ? tx_data : 8'hxx);
            tx_pop <= 1'b1;
            @(posedge clock);
            tx_pop <= 1'b0;
            tx_shifter_empty <= 1'b0;
            repeat (hold + 1) @(posedge clock);
            tx_shifter_empty <= 1'b1;
        end
    endtask
endmodule

// file: test/uart_fifo_irq_dma_signaling_test.sv
`include "uart_consts.svh"
module uart_fifo_irq_dma_signaling_test;
    timeunit 1ns;
    timeprecision 1ps;
    import uart_pkg::*;
    logic        clock, rst, hsel, hwrite, hresp, hreadyout, rd_ph;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic        rx_push, char_tick, tx_valid, tx_pop, tx_shifter_empty;
    logic        irq, tx_request_n, rx_request_n, tick_en;
    byte_t       rx_push_data, tx_data;
    err_t        rx_push_err;
    logic [31:0] exp_q[$];
    byte_t       rxq[$], txq[$];
    int          errors, n_tests, i, t;
    int          rxl[4] = '{8, 16, 24, 28};
    int          txl[4] = '{16, 8, 24, 30};

    uart_fifo_irq_dma i_uart_fifo_irq_dma (.clock(clock), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_push(rx_push), .rx_push_data(rx_push_data),
        .rx_push_err(rx_push_err), .char_tick(char_tick),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_pop(tx_pop),
        .tx_shifter_empty(tx_shifter_empty), .irq(irq),
        .tx_request_n(tx_request_n), .rx_request_n(rx_request_n));
    uart_line_model i_uart_line_model (.clock(clock), .tick_en(tick_en),
        .tx_valid(tx_valid), .tx_data(tx_data), .rx_push(rx_push),
        .rx_push_data(rx_push_data), .rx_push_err(rx_push_err),
        .char_tick(char_tick), .tx_pop(tx_pop),
        .tx_shifter_empty(tx_shifter_empty));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("BAD at %0t got %h expected %h", $time, g, e);
        end
    endtask

    task tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            errors++;
            tally_and_finish();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] e);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        if (!w) exp_q.push_back(e);
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= !w;
        wait_rdy();
        rd_ph <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, e);
    endtask

    task automatic push(input err_t e);
        byte_t v;
        v = byte_t'($urandom);
        rxq.push_back(v);
        i_uart_line_model.send(v, e);
    endtask

    task automatic wr_tx;
        byte_t v;
        v = byte_t'($urandom);
        txq.push_back(v);
        wr(`HOLD_OFF, {24'h0, v});
    endtask

    task automatic rd_rx;
        rd(`HOLD_OFF, {24'h0, rxq.pop_front()});
    endtask

    task automatic pins(input logic q, input logic tq, input logic rq);
        repeat (3) @(posedge clock);
        chk({hresp, irq, tx_request_n, rx_request_n}, {1'b0, q, tq, rq});
    endtask

    task automatic cmp_tx;
        while (i_uart_line_model.got_q.size() > 0)
            chk(i_uart_line_model.got_q.pop_front(), txq.pop_front());
        txq.delete();
    endtask

    // Read data is judged at the edge that ends its data phase
    always @(posedge clock)
        if (rd_ph === 1'b1) chk(hrdata, exp_q.pop_front());

    initial begin
        #400us;
        errors++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rd_ph = 1'b0;
        tick_en = 1'b0;
        errors = 0;
        n_tests = 0;
        void'($urandom(32'h67fb_0da4));
        repeat (4) @(posedge clock);
        chk({hresp, irq, tx_request_n, rx_request_n}, 4'b0011);
        rst <= 1'b0;
        @(posedge clock);
        pins(0, 0, 1);
        rd(`LINE_OFF, 32'h60);
        rd(`SRC_OFF, {26'h0, `SRC_NONE});
        rd(`MASK_OFF, 32'h0);
        rd(8'h10, 32'h0);
        wr(`MASK_OFF, 32'h1);
        rd(`MASK_OFF, 32'h1);
        wr(`SRC_OFF, 32'hfa);
        push(3'h0);
        push(3'h0);
        rd(`LINE_OFF, 32'h63);
        for (t = 0; t < 4; t++) begin
            wr(`SRC_OFF, {24'h0, 2'(t), 6'h0b});
            rxq.delete();
            repeat (rxl[t] - 1) push(3'h0);
            pins(0, 0, 1);
            push(3'h0);
            pins(1, 0, 0);
            rd(`SRC_OFF, {26'h0, `SRC_RX});
            rd_rx();
            pins(0, 0, 0);
        end
        repeat (5) push(3'h0);
        rd(`LINE_OFF, 32'h61);
        push(3'h0);
        rd(`LINE_OFF, 32'h63);
        wr(`MASK_OFF, 32'h0);
        wr(`SRC_OFF, 32'h03);
        rxq.delete();
        repeat (8) push(3'h0);
        pins(0, 0, 0);
        rd(`LINE_OFF, 32'h61);
        repeat (8) rd_rx();
        pins(0, 0, 1);
        rd(`LINE_OFF, 32'h60);
        wr(`MASK_OFF, 32'h4);
        for (i = 0; i < 3; i++) begin
            push(err_t'(1 << i));
            rd(`LINE_OFF, 32'he1 | (32'h4 << i));
            pins(1, 0, 0);
            rd(`SRC_OFF, {26'h0, `SRC_LINE});
            rd_rx();
            rd(`LINE_OFF, 32'h60);
        end
        wr(`MASK_OFF, 32'h1);
        wr(`SRC_OFF, 32'h0b);
        rxq.delete();
        push(3'h0);
        pins(0, 0, 1);
        tick_en <= 1'b1;
        repeat (60) @(posedge clock);
        pins(1, 0, 0);
        tick_en <= 1'b0;
        rd(`SRC_OFF, {26'h0, `SRC_TIMEOUT});
        rd_rx();
        pins(0, 0, 1);
        wr(`SRC_OFF, 32'h05);
        wr(`MASK_OFF, 32'h2);
        wr_tx();
        pins(0, 1, 1);
        rd(`LINE_OFF, 32'h00);
        fork
            i_uart_line_model.drain(1, 20);
        join_none
        repeat (6) @(posedge clock);
        rd(`LINE_OFF, 32'h20);
        pins(1, 0, 1);
        rd(`SRC_OFF, {26'h0, `SRC_TX});
        pins(0, 0, 1);
        repeat (20) @(posedge clock);
        rd(`LINE_OFF, 32'h60);
        wr_tx();
        i_uart_line_model.drain(1, 2);
        pins(1, 0, 1);
        wr_tx();
        pins(0, 1, 1);
        i_uart_line_model.drain(1, 2);
        rd(`SRC_OFF, {26'h0, `SRC_TX});
        cmp_tx();
        for (t = 0; t < 4; t++) begin
            wr(`SRC_OFF, {24'h0, 2'b00, 2'(t), 4'hd});
            repeat (32) wr_tx();
            pins(0, 1, 1);
            i_uart_line_model.drain(32 - txl[t], 0);
            pins(0, 1, 1);
            i_uart_line_model.drain(1, 0);
            pins(1, 0, 1);
            rd(`SRC_OFF, {26'h0, `SRC_TX});
            cmp_tx();
        end
        tally_and_finish();
    end
endmodule
